// File: core/dit_pkg.sv
// constants shared by both ends of the decade interval timer
// Function
// - output command loads 3-bit interval selection
// - interval is ten to (n-1) milliseconds
// - output data bits 3..15 are ignored
// - input command returns status, only bit 4
// - bit 4 set when an interval lost
// - software checks status after each interval
// - software counts decades for other durations
// - set-control starts the interval counting
// - skip-on-flag reports elapsed interval
// - clear-control stops the decade counters
// - run gates reference; clear-flag clears flag, buffer
// - interval end sets buffer, flag at T2
// - output clears selection, counters, then loads
// - preset sets flag; control reset stops counters
`default_nettype none
package dit_pkg;
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned REF_HZ = 100_000;
  localparam int unsigned REF_DIV = CLK_HZ / REF_HZ;
  localparam int unsigned SEL_W = 3;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned DECADES = 8;
  localparam int unsigned LOST_BIT = 4;
  // host command codes
  localparam logic [2:0] CMD_OUT = 3'h1;
  localparam logic [2:0] CMD_IN = 3'h2;
  localparam logic [2:0] CMD_STC = 3'h3;
  localparam logic [2:0] CMD_CLC = 3'h4;
  localparam logic [2:0] CMD_CLF = 3'h5;
  localparam logic [2:0] CMD_SFS = 3'h6;
  localparam logic [2:0] CMD_PRE = 3'h7;
  // wishbone register offsets of the host controller
  localparam logic [3:0] A_CMD = 4'h0;
  localparam logic [3:0] A_DATA = 4'h4;
  localparam logic [3:0] A_STAT = 4'h8;
  localparam logic [3:0] A_IRQ_ST = 4'hc;
  // host phase sequencer length and phase numbers
  localparam logic [2:0] PH_T2 = 3'h1;
  localparam logic [2:0] PH_T3 = 3'h2;
  localparam logic [2:0] PH_T4 = 3'h3;
  localparam logic [2:0] PH_LAST = 3'h5;
endpackage : dit_pkg
`default_nettype wire

// File: core/dit_if.sv
// host i/o bus between the host controller and the timer card
`default_nettype none
interface dit_if;
  logic [2:0] cmd;
  logic cmd_t3;
  logic flag_enable_phase;
  logic power_on_preset;
  logic control_reset;
  logic io_output_strobe;
  logic [15:0] io_output_data_bits;
  logic [15:0] io_input_data_bits;
  logic skip_on_flag;
  logic irq_req;
  modport host (
    output cmd, cmd_t3, flag_enable_phase, power_on_preset, control_reset,
    output io_output_strobe, io_output_data_bits,
    input io_input_data_bits, skip_on_flag, irq_req
  );
  modport card (
    input cmd, cmd_t3, flag_enable_phase, power_on_preset, control_reset,
    input io_output_strobe, io_output_data_bits,
    output io_input_data_bits, skip_on_flag, irq_req
  );
endinterface : dit_if
`default_nettype wire

// File: core/dit_card.sv
// decade interval timer card: selection, decade chain, flag logic
`default_nettype none
module dit_card #(
  parameter int unsigned REF_DIV_P = dit_pkg::REF_DIV
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // host bus
  dit_if.card bus
);
  import dit_pkg::*;
  localparam int unsigned PW = $clog2(REF_DIV_P + 1);
  localparam logic [3:0] DIG_MAX = 4'h9;

  logic [SEL_W-1:0] sel_r, sel_nxt;
  logic run_flipflop_r, run_flipflop_nxt;
  logic flag_hold_stage_r, flag_hold_stage_nxt;
  logic flag_r, flag_nxt;
  logic lost_r, lost_nxt;
  logic [PW-1:0] pre_r, pre_nxt;
  logic [3:0] dig_r [DECADES], dig_nxt [DECADES];
  logic [15:0] in_r, in_nxt;
  logic [DECADES:0] carry;
  logic tick, iv_end, clr_chain, skip_if_flag_set_cmd;

  assign tick = run_flipflop_r && (pre_r == PW'(REF_DIV_P - 1));
  assign carry[0] = tick;
  genvar g;
  generate
    for (g = 0; g < DECADES; g++)
    begin : g_dec
      assign carry[g+1] = carry[g] && (dig_r[g] == DIG_MAX);
    end
  endgenerate
  // interval k ends at the carry out of decade k
  // widened index so that code 7 reaches the last carry out
  assign iv_end = carry[{1'b0, sel_r} + 4'h1];
  assign clr_chain = !run_flipflop_r || bus.io_output_strobe;
  assign skip_if_flag_set_cmd = bus.cmd == CMD_SFS;

  always_comb
  begin
    sel_nxt = sel_r;
    run_flipflop_nxt = run_flipflop_r;
    flag_hold_stage_nxt = flag_hold_stage_r;
    flag_nxt = flag_r;
    lost_nxt = lost_r;
    in_nxt = in_r;
    pre_nxt = pre_r;
    for (int i = 0; i < DECADES; i++)
      dig_nxt[i] = dig_r[i];
    if (bus.io_output_strobe && bus.cmd_t3)
      sel_nxt = '0;
    else if (bus.io_output_strobe && bus.cmd == CMD_OUT)
      sel_nxt = bus.io_output_data_bits[SEL_W-1:0];
    if (bus.cmd == CMD_STC)
      run_flipflop_nxt = 1'b1;
    if (bus.cmd == CMD_CLC || bus.control_reset)
      run_flipflop_nxt = 1'b0;
    if (clr_chain)
    begin
      pre_nxt = '0;
      for (int i = 0; i < DECADES; i++)
        dig_nxt[i] = 4'h0;
    end
    else
    begin
      pre_nxt = tick ? '0 : pre_r + PW'(1);
      for (int i = 0; i < DECADES; i++)
        if (carry[i])
          dig_nxt[i] = (dig_r[i] == DIG_MAX) ? 4'h0 : dig_r[i] + 4'h1;
    end
    if (bus.flag_enable_phase && flag_hold_stage_r)
      flag_nxt = 1'b1;
    if (bus.cmd == CMD_CLF)
    begin
      flag_nxt = 1'b0;
      flag_hold_stage_nxt = 1'b0;
      lost_nxt = 1'b0;
    end
    if (bus.control_reset)
      lost_nxt = 1'b0;
    if (bus.power_on_preset)
      flag_hold_stage_nxt = 1'b1;
    if (iv_end && !clr_chain && (!flag_r || bus.cmd == CMD_CLF))
      flag_hold_stage_nxt = 1'b1;
    if (iv_end && !clr_chain && (flag_r || flag_hold_stage_r))
      lost_nxt = 1'b1;
    // the status word stands until the next input command
    if (bus.cmd == CMD_IN)
    begin
      in_nxt = '0;
      in_nxt[LOST_BIT] = lost_r;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sel_r <= '0;
      run_flipflop_r <= 1'b0;
      flag_hold_stage_r <= 1'b0;
      flag_r <= 1'b0;
      lost_r <= 1'b0;
      pre_r <= '0;
      in_r <= '0;
      for (int i = 0; i < DECADES; i++)
        dig_r[i] <= 4'h0;
    end
    else
    begin
      sel_r <= sel_nxt;
      run_flipflop_r <= run_flipflop_nxt;
      flag_hold_stage_r <= flag_hold_stage_nxt;
      flag_r <= flag_nxt;
      lost_r <= lost_nxt;
      pre_r <= pre_nxt;
      in_r <= in_nxt;
      for (int i = 0; i < DECADES; i++)
        dig_r[i] <= dig_nxt[i];
    end
  end

  assign bus.io_input_data_bits = in_r;
  assign bus.skip_on_flag = skip_if_flag_set_cmd && flag_r;
  assign bus.irq_req = flag_r;
endmodule // dit_card
`default_nettype wire

// File: core/dit_host.sv
// host i/o controller: wishbone slave issuing timer bus commands
`default_nettype none
module dit_host (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // interrupt
  output logic irq,
  // timer bus
  dit_if.host bus
);
  import dit_pkg::*;
  typedef enum logic [1:0] {IDLE = 2'b01, BUSY = 2'b10} st_t;
  st_t st_r, st_nxt;
  logic [2:0] ph_r, ph_nxt, cmd_r, cmd_nxt;
  logic [15:0] odat_r, odat_nxt, idat_r, idat_nxt;
  logic skip_r, skip_nxt, ack_r, ack_nxt;
  logic [1:0] ist_r, ist_nxt, ien_r, ien_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic req, t2, t3;

  assign req = wb_cyc_i && wb_stb_i && !ack_r;
  assign t2 = ph_r == PH_T2;
  assign t3 = ph_r == PH_T3;

  always_comb
  begin
    st_nxt = st_r;
    cmd_nxt = cmd_r;
    odat_nxt = odat_r;
    idat_nxt = idat_r;
    skip_nxt = skip_r;
    ist_nxt = ist_r;
    ien_nxt = ien_r;
    rd_nxt = rd_r;
    ack_nxt = 1'b0;
    ph_nxt = (ph_r == PH_LAST) ? '0 : ph_r + 3'h1;
    if (bus.irq_req)
      ist_nxt[0] = 1'b1;
    unique case (st_r)
      IDLE:
        if (req)
        begin
          if (wb_we_i && wb_adr_i == A_CMD && wb_sel_i[0])
          begin
            // start only at the phase wrap so t2, t3 and t4 all follow
            if (ph_r == PH_LAST)
            begin
              cmd_nxt = wb_dat_i[2:0];
              st_nxt = BUSY;
            end
          end
          else
          begin
            ack_nxt = 1'b1;
            if (wb_we_i && wb_adr_i == A_DATA)
              odat_nxt = wb_dat_i[15:0];
            if (wb_we_i && wb_adr_i == A_IRQ_ST)
              ist_nxt = ist_r & ~wb_dat_i[1:0] | {1'b0, bus.irq_req};
            if (wb_we_i && wb_adr_i == A_STAT)
              ien_nxt = wb_dat_i[1:0];
            unique case (wb_adr_i)
              A_DATA: rd_nxt = {16'h0000, idat_r};
              A_STAT: rd_nxt = {29'h0, skip_r, ien_r};
              A_IRQ_ST: rd_nxt = {30'h0, ist_r};
              default: rd_nxt = 32'h0;
            endcase
          end
        end
      BUSY:
        if (ph_r == PH_LAST)
        begin
          if (cmd_r == CMD_IN)
            idat_nxt = bus.io_input_data_bits;
          if (cmd_r == CMD_SFS)
          begin
            skip_nxt = 1'b0;
            rd_nxt = 32'h0;
          end
          ack_nxt = 1'b1;
          st_nxt = IDLE;
        end
        else if (cmd_r == CMD_SFS && bus.skip_on_flag)
        begin
          skip_nxt = 1'b1;
          ist_nxt[1] = 1'b1;
        end
      default: st_nxt = IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r <= IDLE;
      ph_r <= '0;
      cmd_r <= '0;
      odat_r <= '0;
      idat_r <= '0;
      skip_r <= 1'b0;
      ack_r <= 1'b0;
      ist_r <= '0;
      ien_r <= '0;
      rd_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      ph_r <= ph_nxt;
      cmd_r <= cmd_nxt;
      odat_r <= odat_nxt;
      idat_r <= idat_nxt;
      skip_r <= skip_nxt;
      ack_r <= ack_nxt;
      ist_r <= ist_nxt;
      ien_r <= ien_nxt;
      rd_r <= rd_nxt;
    end
  end

  // commands are driven only inside the busy phase window
  always_comb
  begin
    bus.cmd = '0;
    bus.io_output_strobe = 1'b0;
    bus.cmd_t3 = 1'b0;
    bus.power_on_preset = 1'b0;
    bus.control_reset = 1'b0;
    if (st_r == BUSY && ph_r == PH_T4)
    begin
      bus.cmd = (cmd_r == CMD_PRE) ? 3'h0 : cmd_r;
      bus.io_output_strobe = cmd_r == CMD_OUT;
      bus.power_on_preset = cmd_r == CMD_PRE;
      bus.control_reset = cmd_r == CMD_PRE;
    end
    if (st_r == BUSY && t3 && cmd_r == CMD_OUT)
    begin
      bus.io_output_strobe = 1'b1;
      bus.cmd_t3 = 1'b1;
    end
    if (st_r == BUSY && cmd_r == CMD_SFS && ph_r != PH_LAST)
      bus.cmd = CMD_SFS;
  end
  assign bus.flag_enable_phase = t2;
  assign bus.io_output_data_bits = odat_r;
  assign wb_dat_o = rd_r;
  assign wb_ack_o = ack_r;
  assign irq = |(ist_r & ien_r);
endmodule // dit_host
`default_nettype wire

// File: sim/dit_props.sv
// assertions on the timer bus between host controller and card
`default_nettype none
module dit_props
  import dit_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // timer bus
  input wire logic [2:0] cmd,
  input wire logic cmd_t3,
  input wire logic flag_enable_phase,
  input wire logic power_on_preset,
  input wire logic io_output_strobe,
  input wire logic [15:0] io_input_data_bits,
  input wire logic skip_on_flag,
  input wire logic irq_req
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  a_skip_flag: assert property (
    skip_on_flag == (cmd == CMD_SFS && irq_req))
    else $error("skip differs from flag test");
  a_clf_clears: assert property (
    cmd == CMD_CLF && !flag_enable_phase |=> !irq_req)
    else $error("flag kept after clear");
  a_flag_fall: assert property (
    $fell(irq_req) |-> $past(cmd) == CMD_CLF)
    else $error("flag fell without clear");
  a_flag_t2: assert property (
    $rose(irq_req) |-> $past(flag_enable_phase))
    else $error("flag rose outside t2");
  a_preset_flag: assert property (
    power_on_preset |-> ##[1:7] irq_req)
    else $error("preset did not raise flag");
  a_status_load: assert property (
    $changed(io_input_data_bits) |-> $past(cmd) == CMD_IN)
    else $error("status word moved without input");
  a_t3_load: assert property (
    cmd_t3 |-> io_output_strobe ##1 (io_output_strobe && !cmd_t3))
    else $error("output strobe order wrong");
  a_phase_period: assert property (
    flag_enable_phase |=> !flag_enable_phase [*5] ##1 flag_enable_phase)
    else $error("t2 period wrong");
  cover property (skip_on_flag);
  cover property ($rose(io_input_data_bits[LOST_BIT]));
  cover property (cmd_t3);
endmodule // dit_props
`default_nettype wire

// File: sim/tb_top.sv
// self-checking bench for the host controller and timer card pair
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dit_pkg::*;
  localparam int SIM_DIV = 2;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic ack;
  logic irq;
  int n_mismatch = 0;
  int n_checks = 0;
  int cc = 0;
  always #2 clk = ~clk;
  dit_if bif ();
  dit_host dit_host_inst (.clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq(irq),
    .bus(bif.host));
  dit_card #(.REF_DIV_P(SIM_DIV)) dit_card_inst (.clk(clk), .arst_n(arst_n),
    .bus(bif.card));
  dit_props dit_props_inst (.clk(clk), .arst_n(arst_n), .cmd(bif.cmd),
    .cmd_t3(bif.cmd_t3), .flag_enable_phase(bif.flag_enable_phase),
    .power_on_preset(bif.power_on_preset),
    .io_output_strobe(bif.io_output_strobe),
    .io_input_data_bits(bif.io_input_data_bits),
    .skip_on_flag(bif.skip_on_flag), .irq_req(bif.irq_req));
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one classic wishbone cycle, read data left in rd
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hf;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task cmd(input logic [2:0] c);
    wb(1'b1, A_CMD, {29'h0, c});
  endtask
  task wflag;
    while (bif.irq_req !== 1'b1)
      @(posedge clk);
  endtask
  task t_skip;
    cmd(CMD_SFS);
    wb(1'b0, A_IRQ_ST, 32'h0);
    chk(rd & 32'h2, 32'h0);
    cmd(CMD_PRE);
    repeat (8) @(posedge clk);
    chk(32'(bif.irq_req), 32'h1);
    cmd(CMD_SFS);
    wb(1'b0, A_IRQ_ST, 32'h0);
    chk(rd & 32'h2, 32'h2);
    $display("test skip done");
  endtask
  task t_interval;
    int t1;
    int n;
    for (int s = 0; s < 4; s++)
    begin
      n = SIM_DIV * (REF_HZ / 10000) * (10 ** s);
      // upper bits set must not disturb the selection
      wb(1'b1, A_DATA, 32'hfff8 | 32'(s));
      cmd(CMD_OUT);
      cmd(CMD_CLF);
      cmd(CMD_STC);
      t1 = cc;
      wflag;
      chk(32'(cc - t1 >= n - 8 && cc - t1 <= n + 8), 32'h1);
      t1 = cc;
      cmd(CMD_CLF);
      wflag;
      chk(32'(cc - t1 >= n - 6 && cc - t1 <= n + 6), 32'h1);
      cmd(CMD_CLC);
    end
    $display("test interval done");
  endtask
  task t_lost;
    wb(1'b1, A_DATA, 32'h0);
    cmd(CMD_OUT);
    cmd(CMD_CLF);
    cmd(CMD_STC);
    wflag;
    repeat (50) @(posedge clk);
    cmd(CMD_IN);
    wb(1'b0, A_DATA, 32'h0);
    chk(rd & 32'h10, 32'h10);
    cmd(CMD_CLC);
    cmd(CMD_CLF);
    repeat (300) @(posedge clk);
    chk(32'(bif.irq_req), 32'h0);
    cmd(CMD_IN);
    wb(1'b0, A_DATA, 32'h0);
    chk(rd & 32'h10, 32'h0);
    $display("test lost done");
  endtask
  // three 1 ms decades counted to form a 3 ms delay
  task t_chain;
    int t1;
    int n;
    n = SIM_DIV * (REF_HZ / 1000);
    wb(1'b1, A_DATA, 32'h1);
    cmd(CMD_OUT);
    cmd(CMD_CLF);
    cmd(CMD_STC);
    t1 = cc;
    for (int k = 0; k < 3; k++)
    begin
      wflag;
      if (k == 2)
        chk(32'(cc - t1 >= 3 * n - 8 && cc - t1 <= 3 * n + 8), 32'h1);
      cmd(CMD_IN);
      wb(1'b0, A_DATA, 32'h0);
      chk(rd & 32'h10, 32'h0);
      cmd(CMD_CLF);
    end
    cmd(CMD_CLC);
    $display("test chain done");
  endtask
  task t_irq;
    wb(1'b1, A_STAT, 32'h1);
    cmd(CMD_STC);
    wflag;
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1);
    wb(1'b1, A_STAT, 32'h0);
    @(posedge clk);
    chk(32'(irq), 32'h0);
    cmd(CMD_CLC);
    cmd(CMD_CLF);
    wb(1'b1, A_IRQ_ST, 32'h3);
    wb(1'b1, 4'h2, 32'h0);
    wb(1'b1, A_STAT, 32'h1);
    wb(1'b0, A_IRQ_ST, 32'h0);
    chk(rd & 32'h1, 32'h0);
    chk(32'(irq), 32'h0);
    $display("test irq done");
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    t_skip;
    t_interval;
    t_lost;
    t_chain;
    t_irq;
    end_sim;
  end
  always @(posedge clk)
  begin
    cc <= cc + 1;
    if (cc == 90000)
    begin
      n_mismatch++;
      end_sim;
    end
  end
endmodule // tb_top
`default_nettype wire
